// ### tb.sv
// self-checking bench of the up/down timer control block
`timescale 1ns/1ps
module tb;
    logic        clk, rst_n, req, we, ack, dwn, run, cp, dp, d;
    logic [3:0]  adr, sel;
    logic [31:0] wd, q, rdat;
    logic [15:0] cnt, r;
    logic [1:0]  kd;
    logic [3:0]  ads [4] = '{4'h0, 4'h4, 4'h8, 4'h2};
    logic [1:0]  pat [4] = '{2'd1, 2'd3, 2'd2, 2'd3};
    int          error_cnt, compares, k;
    udt_top udt_top_i (
        .i_mclk(clk), .i_reset_n(rst_n), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_count_pulse_input(cp), .i_direction_pulse_input(dp), .o_count(cnt),
        .o_count_down(dwn), .o_running(run)
    );
    udt_pin_model udt_pin_model_i (.i_clk(clk), .o_cnt_pin(cp), .o_dir_pin(dp));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // cyc and stb share one line: they always rise and fall together
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dt);
        int n;
        n = 0;
        {req, we, adr, wd} <= {1'b1, w, a, dt};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
        q = rdat;
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q, exp);
    endtask
    // waits for the counter to leave r, then checks the single step
    task automatic step(input logic [15:0] exp, input string nm);
        int n;
        n = 0;
        while (cnt === r && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (cnt === r) begin
            error_cnt++;
            tally_and_finish();
        end
        chk(nm, {16'h0000, cnt}, {16'h0000, exp});
        r = exp;
    endtask
    initial begin
        error_cnt = 0;
        compares = 0;
        {req, we, adr, wd, rst_n} = '0;
        sel = 4'hF;
        void'($urandom(32'h4df1));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 4; k++) begin
            rd(ads[k], 32'h0000_0000, "reset or unmapped");
        end
        bus(1'b1, 4'h2, $urandom);
        rd(4'h2, 32'h0000_0000, "unmapped");
        sel <= 4'h0;
        bus(1'b1, 4'h4, 32'h0000_0080);
        sel <= 4'hF;
        rd(4'h4, 32'h0000_0000, "lane off");
        $display("register access done");
        r = 16'($urandom);
        bus(1'b1, 4'h8, {16'h0000, r});
        bus(1'b1, 4'h4, 32'h0000_00A3);
        step(r + 16'h0001, "count up");
        rd(4'h4, 32'h0000_0083, "ctrl dir");
        rd(4'hC, 32'h0000_0001, "status");
        bus(1'b1, 4'h4, 32'h0000_0000);
        $display("internal up done");
        bus(1'b1, 4'h0, 32'h0000_0080);
        bus(1'b1, 4'h4, 32'h0000_0023);
        rd(4'h4, 32'h0000_0003, "ctrl stopped");
        r = 16'($urandom);
        bus(1'b1, 4'h8, {16'h0000, r});
        bus(1'b1, 4'h4, 32'h0000_00A3);
        rd(4'h4, 32'h0000_00A3, "ctrl dir");
        step(r - 16'h0001, "count down");
        chk("running", {31'h0, run}, 32'h0000_0001);
        rd(4'hC, 32'h0000_0003, "status down");
        bus(1'b1, 4'h4, 32'h0000_0000);
        $display("internal down done");
        // the unused edge select is off, so a count proves that it was ignored
        bus(1'b1, 4'h0, {24'h0, 4'h8, 2'b11, 2'b00});
        udt_pin_model_i.drive(1'b0, 1'b1, 6);
        r = 16'($urandom);
        bus(1'b1, 4'h8, {16'h0000, r});
        bus(1'b1, 4'h4, 32'h0000_00B0);
        rd(4'h4, 32'h0000_00B0, "ctrl live down");
        udt_pin_model_i.drive(1'b1, 1'b1, 4);
        udt_pin_model_i.drive(1'b0, 1'b0, 6);
        step(r - 16'h0001, "ext count");
        rd(4'h4, 32'h0000_0090, "ctrl live up");
        bus(1'b1, 4'h4, 32'h0000_0000);
        $display("external done");
        bus(1'b1, 4'h0, {24'h0, 4'hC, 2'($urandom), 2'b11});
        r = 16'($urandom);
        bus(1'b1, 4'h8, {16'h0000, r});
        bus(1'b1, 4'h4, 32'h0000_0090);
        d = 1'b0;
        for (k = 0; k < 10; k++) begin
            kd = (k < 4) ? pat[k] : 2'(1 + $urandom % 3);
            if (kd != 2'd3) d = kd[1];
            udt_pin_model_i.drive(kd[0], kd[1], 3 + $urandom % 5);
            udt_pin_model_i.drive(1'b0, 1'b0, 5);
            step(d ? r - 16'h0001 : r + 16'h0001, "two-pin count");
            chk("down flag", {31'h0, dwn}, {31'h0, d});
        end
        $display("two-pin done");
        tally_and_finish();
    end
endmodule // tb

// ### udt_defs.svh
// offsets, reset values and timing counts of the up/down timer control block
`ifndef UDT_DEFS_SVH
`define UDT_DEFS_SVH

// byte addresses of the word registers
`define UDT_ADR_MODE        4'h0
`define UDT_ADR_CTRL        4'h4
`define UDT_ADR_COUNT       4'h8
`define UDT_ADR_STATUS      4'hC

// timer_unit_mode_reg field positions
`define UDT_MODE_PIN_EDGE_LO 0
`define UDT_MODE_PIN_EDGE_HI 1
`define UDT_MODE_EXT_EDGE_LO 2
`define UDT_MODE_EXT_EDGE_HI 3
`define UDT_MODE_CMODE_LO    4
`define UDT_MODE_CMODE_HI    6
`define UDT_MODE_DIR_CTL     7

// updown_timer_control_reg field positions
`define UDT_CTRL_PSC_LO     0
`define UDT_CTRL_PSC_HI     1
`define UDT_CTRL_CLK_EXT    4
`define UDT_CTRL_DIR        5
`define UDT_CTRL_MODE_EN    6
`define UDT_CTRL_RUN        7

// reset values
`define UDT_MODE_RESET      8'h00
`define UDT_CTRL_RESET      8'h00
`define UDT_COUNT_RESET     16'h0000

// counting mode that uses both pulse inputs
`define UDT_CMODE_TWO_PIN   3'h4

// prescaler terminal counts: divide by 2, 4, 8 and 16
`define UDT_PSC_LIMIT0      4'h1
`define UDT_PSC_LIMIT1      4'h3
`define UDT_PSC_LIMIT2      4'h7
`define UDT_PSC_LIMIT3      4'hF

`endif

// ### udt_pin_model.sv
// far-side model driving the count and direction pulse pins
`timescale 1ns/1ps
module udt_pin_model (
    input  logic i_clk,
    output logic o_cnt_pin,
    output logic o_dir_pin
);
    initial begin
        o_cnt_pin = 1'b0;
        o_dir_pin = 1'b0;
    end
    // levels change just after an edge and stand n cycles; under two the pin filter drops them
    task automatic drive(input logic c, input logic d, input int n);
        o_cnt_pin <= c;
        o_dir_pin <= d;
        repeat (n) @(posedge i_clk);
    endtask
endmodule // udt_pin_model

// ### udt_pin_sync.sv
// three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module udt_pin_sync (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_pin,
    output udt_pkg::udt_pin_t o_pin
);
    import udt_pkg::*;

    logic [2:0] sync_ff;
    logic       level_ff;
    udt_pin_t   pin_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], i_pin};
        end
    end

    // stage 0 is only read by stage 1; a change counts once stages 1 and 2 agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_ff <= 1'b0;
            pin_ff   <= '0;
        end else begin
            if (sync_ff[1] == sync_ff[2]) begin
                level_ff <= sync_ff[2];
            end
            pin_ff.level <= level_ff;
            pin_ff.rise  <= (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !level_ff;
            pin_ff.fall  <= (sync_ff[1] == sync_ff[2]) && !sync_ff[2] && level_ff;
        end
    end

    assign o_pin = pin_ff;

endmodule // udt_pin_sync

// ### udt_pkg.sv
// types shared by the up/down timer control block
package udt_pkg;

    typedef enum logic [1:0] {
        UDT_EDGE_RISE = 2'b00,
        UDT_EDGE_FALL = 2'b01,
        UDT_EDGE_BOTH = 2'b10,
        UDT_EDGE_NONE = 2'b11
    } udt_edge_sel_t;

    // timer_unit_mode_reg layout
    typedef struct packed {
        logic          dir_ctl;
        logic [2:0]    count_mode;
        udt_edge_sel_t ext_edge;
        udt_edge_sel_t pin_edge;
    } udt_mode_t;

    // updown_timer_control_reg layout
    typedef struct packed {
        logic       count_run_bit;
        logic       mode_enable_bit;
        logic       count_dir_bit;
        logic       clk_ext;
        logic [1:0] rsv;
        logic       prescaler_select_hi;
        logic       prescaler_select_lo;
    } udt_ctrl_t;

    // synchronised pin with its edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } udt_pin_t;

endpackage

// ### udt_top.sv
// up/down timer with its mode and control registers on a classic wishbone slave
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_top (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_count_pulse_input,
    input  wire logic        i_direction_pulse_input,
    output logic      [15:0] o_count,
    output logic             o_count_down,
    output logic             o_running
);
    import udt_pkg::*;

    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    udt_pin_t    cnt_pin;
    udt_pin_t    dir_pin;

    udt_mode_t   mode_ff;
    udt_ctrl_t   ctrl_ff;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic        dir_state_ff;
    logic        nxt_dir_state;
    logic        down_ff;
    logic        nxt_down;
    logic [3:0]  psc_cnt_ff;
    logic [3:0]  psc_limit;
    logic        tick_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    logic        wr_req;
    logic        wr_mode;
    logic        wr_ctrl;
    logic        wr_count_lo;
    logic        wr_count_hi;
    logic        two_pin;
    logic        ext_clk;
    logic        count_event;
    logic        up_edge;
    logic        dn_edge;

    // reset is asserted at once and released through two flops
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    udt_pin_sync u_cnt_sync (
        .i_clk   (i_mclk),
        .i_rst_n (rst_n),
        .i_pin   (i_count_pulse_input),
        .o_pin   (cnt_pin)
    );

    udt_pin_sync u_dir_sync (
        .i_clk   (i_mclk),
        .i_rst_n (rst_n),
        .i_pin   (i_direction_pulse_input),
        .o_pin   (dir_pin)
    );

    // a write is performed at the edge that raises ack
    assign wr_req      = i_wb_cyc && i_wb_stb && i_wb_we && !ack_ff;
    assign wr_mode     = wr_req && i_wb_sel[0] && (i_wb_adr == `UDT_ADR_MODE);
    assign wr_ctrl     = wr_req && i_wb_sel[0] && (i_wb_adr == `UDT_ADR_CTRL);
    assign wr_count_lo = wr_req && i_wb_sel[0] && (i_wb_adr == `UDT_ADR_COUNT);
    assign wr_count_hi = wr_req && i_wb_sel[1] && (i_wb_adr == `UDT_ADR_COUNT);

    assign ext_clk = ctrl_ff.clk_ext;
    assign two_pin = mode_ff.dir_ctl && ext_clk && (mode_ff.count_mode == `UDT_CMODE_TWO_PIN);

    // software is trusted not to touch this while running
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= `UDT_MODE_RESET;
        end else if (wr_mode) begin
            mode_ff <= i_wb_dat[7:0];
        end
    end

    // control register; the direction bit has its own write rules
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `UDT_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff.count_run_bit       <= i_wb_dat[`UDT_CTRL_RUN];
                ctrl_ff.mode_enable_bit     <= i_wb_dat[`UDT_CTRL_MODE_EN];
                ctrl_ff.clk_ext             <= i_wb_dat[`UDT_CTRL_CLK_EXT];
                ctrl_ff.prescaler_select_hi <= i_wb_dat[`UDT_CTRL_PSC_HI];
                ctrl_ff.prescaler_select_lo <= i_wb_dat[`UDT_CTRL_PSC_LO];
            end
            ctrl_ff.rsv <= 2'h0;
            if (!mode_ff.dir_ctl) begin
                ctrl_ff.count_dir_bit <= 1'b0;
            end else if (wr_ctrl && !i_wb_dat[`UDT_CTRL_RUN]) begin
                ctrl_ff.count_dir_bit <= 1'b0;
            end else if (wr_ctrl && !i_wb_dat[`UDT_CTRL_CLK_EXT]) begin
                // run and direction written together start a down count
                ctrl_ff.count_dir_bit <= i_wb_dat[`UDT_CTRL_DIR];
            end else if (wr_ctrl) begin
                ctrl_ff.count_dir_bit <= 1'b0;
            end else if (!ctrl_ff.count_run_bit) begin
                ctrl_ff.count_dir_bit <= 1'b0;
            end
        end
    end

    always_comb begin
        case ({ctrl_ff.prescaler_select_hi, ctrl_ff.prescaler_select_lo})
            2'b00:   psc_limit = `UDT_PSC_LIMIT0;
            2'b01:   psc_limit = `UDT_PSC_LIMIT1;
            2'b10:   psc_limit = `UDT_PSC_LIMIT2;
            default: psc_limit = `UDT_PSC_LIMIT3;
        endcase
    end

    // internal count clock as a one-cycle enable from the prescaler
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            psc_cnt_ff <= 4'h0;
            tick_ff    <= 1'b0;
        end else if (!ctrl_ff.count_run_bit || ext_clk) begin
            psc_cnt_ff <= 4'h0;
            tick_ff    <= 1'b0;
        end else if (psc_cnt_ff >= psc_limit) begin
            psc_cnt_ff <= 4'h0;
            tick_ff    <= 1'b1;
        end else begin
            psc_cnt_ff <= psc_cnt_ff + 4'h1;
            tick_ff    <= 1'b0;
        end
    end

    function automatic logic edge_hit(input udt_edge_sel_t sel, input udt_pin_t pin);
        case (sel)
            UDT_EDGE_RISE: edge_hit = pin.rise;
            UDT_EDGE_FALL: edge_hit = pin.fall;
            UDT_EDGE_BOTH: edge_hit = pin.rise || pin.fall;
            default:       edge_hit = 1'b0;
        endcase
    endfunction

    // in mode four with direction control and the external clock the edge select is bypassed: rising edges count on either pin
    assign up_edge = two_pin && cnt_pin.rise;
    assign dn_edge = two_pin && dir_pin.rise;

    always_comb begin
        if (!ctrl_ff.count_run_bit) begin
            count_event = 1'b0;
        end else if (!ext_clk) begin
            count_event = tick_ff;
        end else if (two_pin) begin
            count_event = up_edge || dn_edge;
        end else if (mode_ff.dir_ctl) begin
            count_event = edge_hit(mode_ff.pin_edge, cnt_pin);
        end else begin
            count_event = edge_hit(mode_ff.ext_edge, cnt_pin);
        end
    end

    // live up/down state used with the external clock; 1 means down
    always_comb begin
        nxt_dir_state = dir_state_ff;
        if (!ctrl_ff.count_run_bit || !mode_ff.dir_ctl || !ext_clk) begin
            nxt_dir_state = 1'b0;
        end else if (two_pin) begin
            if (up_edge && !dn_edge) begin
                nxt_dir_state = 1'b0;
            end else if (dn_edge && !up_edge) begin
                nxt_dir_state = 1'b1;
            end
            // both edges at once leave the direction as it was
        end else begin
            nxt_dir_state = dir_pin.level;
        end
    end

    always_comb begin
        if (!mode_ff.dir_ctl) begin
            nxt_down = 1'b0;
        end else if (ext_clk) begin
            nxt_down = nxt_dir_state;
        end else begin
            nxt_down = ctrl_ff.count_dir_bit;
        end
    end

    always_comb begin
        nxt_count = count_ff;
        if (count_event) begin
            nxt_count = nxt_down ? count_ff - 16'h0001 : count_ff + 16'h0001;
        end
        // a preload wins over a count in the same cycle
        if (wr_count_lo) begin
            nxt_count[7:0] = i_wb_dat[7:0];
        end
        if (wr_count_hi) begin
            nxt_count[15:8] = i_wb_dat[15:8];
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff     <= `UDT_COUNT_RESET;
            dir_state_ff <= 1'b0;
            down_ff      <= 1'b0;
        end else begin
            count_ff     <= nxt_count;
            dir_state_ff <= nxt_dir_state;
            down_ff      <= nxt_down;
        end
    end

    always_comb begin
        nxt_rdat = 32'h0000_0000;
        case (i_wb_adr)
            `UDT_ADR_MODE: begin
                nxt_rdat[7:0] = mode_ff;
            end
            `UDT_ADR_CTRL: begin
                nxt_rdat[7:0] = ctrl_ff;
                // external clock shows the live direction instead of the written bit
                if (!mode_ff.dir_ctl) begin
                    nxt_rdat[`UDT_CTRL_DIR] = 1'b0;
                end else if (ext_clk) begin
                    nxt_rdat[`UDT_CTRL_DIR] = dir_state_ff;
                end
            end
            `UDT_ADR_COUNT: begin
                nxt_rdat[15:0] = count_ff;
            end
            `UDT_ADR_STATUS: begin
                nxt_rdat[1:0] = {down_ff, ctrl_ff.count_run_bit};
            end
            default: begin
                nxt_rdat = 32'h0000_0000;
            end
        endcase
    end

    // one-cycle answer; unmapped addresses ack and read zero
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= i_wb_cyc && i_wb_stb && !ack_ff;
            if (i_wb_cyc && i_wb_stb && !ack_ff && !i_wb_we) begin
                rdat_ff <= nxt_rdat;
            end
        end
    end

    assign o_wb_ack     = ack_ff;
    assign o_wb_dat     = rdat_ff;
    assign o_count      = count_ff;
    assign o_count_down = down_ff;
    assign o_running    = ctrl_ff.count_run_bit;

endmodule // udt_top

// ### udt_top_asserts.sv
// port assertions of the up/down timer, bound to its top
`timescale 1ns/1ps
module udt_top_chk (
    input logic        i_mclk,
    input logic        i_reset_n,
    input logic        i_wb_cyc,
    input logic        i_wb_stb,
    input logic        i_wb_we,
    input logic [3:0]  i_wb_adr,
    input logic [31:0] i_wb_dat,
    input logic [3:0]  i_wb_sel,
    input logic [31:0] o_wb_dat,
    input logic        o_wb_ack,
    input logic [15:0] o_count,
    input logic        o_running
);
    logic tk, cw, kw, dctl_ff, ext_ff, dir_ff;
    assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign cw = tk && i_wb_we && i_wb_adr == 4'h8;
    assign kw = tk && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h4;
    // shadows of written fields, since the ports do not show them
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {dctl_ff, ext_ff, dir_ff} <= 3'b000;
        end else begin
            if (tk && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h0) begin
                dctl_ff <= i_wb_dat[7];
            end
            if (kw) begin
                ext_ff <= i_wb_dat[4];
                dir_ff <= i_wb_dat[7] && i_wb_dat[5];
            end
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_rd(a);
        tk && !i_wb_we && i_wb_adr == a;
    endsequence
    // a counter step that no bus write caused
    sequence s_step;
        $changed(o_count) && !$past(cw);
    endsequence
    property p_ack; tk |=> o_wb_ack; endproperty
    property p_hole; s_rd(4'h2) |=> o_wb_dat == 32'h0000_0000; endproperty
    property p_stop; kw && !i_wb_dat[7] |=> !o_running; endproperty
    property p_nodir; s_rd(4'h4) ##0 !dctl_ff |=> !o_wb_dat[5]; endproperty
    property p_idle; s_rd(4'h4) ##0 (!o_running && !ext_ff) |=> !o_wb_dat[5]; endproperty
    property p_back; s_rd(4'h4) ##0 (dctl_ff && !ext_ff && o_running) |=> o_wb_dat[5] == dir_ff; endproperty
    property p_up; s_step ##0 !dctl_ff |-> o_count == $past(o_count) + 16'h0001; endproperty
    property p_down; s_step ##0 (dctl_ff && !ext_ff && dir_ff) |-> o_count == $past(o_count) - 16'h0001; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    a_stop: assert property (p_stop) else $error("run flag kept after stop write");
    a_nodir: assert property (p_nodir) else $error("dir bit set without direction control");
    a_idle: assert property (p_idle) else $error("dir bit set while stopped");
    a_back: assert property (p_back) else $error("dir bit readback wrong");
    a_up: assert property (p_up) else $error("count not upward");
    a_down: assert property (p_down) else $error("count not downward");
endmodule // udt_top_chk

bind udt_top udt_top_chk udt_top_chk_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_count(o_count), .o_running(o_running)
);
